// ---- pesd_top.sv ----
// Event-select decoder: select registers, eight event counters and their register port.
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
`include "pesd_params.svh"
module pesd_top #(
	parameter int CNT_W = 32
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        proc_running,
	input  wire logic        trace_to_rom_switch_event,
	input  wire logic        src_trace_build,
	input  wire logic        src_trace_deliver,
	input  wire logic        src_rom,
	input  wire logic        br_retire,
	input  wire logic        br_mispred,
	input  wire logic [3:0]  br_type
);
	if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
		$error("pesd_top: CNT_W must lie between 2 and 32");
	end

	logic [31:0]      event_select_control_reg [`PESD_N_EVENT_SELECT_CONTROL_REG];
	logic [31:0]      counter_config_control_reg [`PESD_N_CNT];
	logic [CNT_W-1:0] cnt  [`PESD_N_CNT];
	logic [1:0]       inc  [`PESD_N_CNT];
	logic [2:0]       rgn;
	logic [2:0]       idx;
	logic             aligned;
	logic             event_select_control_reg_hit;
	logic             counter_config_control_reg_hit;
	logic             cnt_hit;
	logic [31:0]      next_rdata;

	pesd_event_if ev ();

	assign ev.running    = proc_running;
	assign ev.rom_switch = trace_to_rom_switch_event;
	assign ev.uq_src     = {src_rom, src_trace_deliver, src_trace_build};
	assign ev.br_retire  = br_retire;
	assign ev.br_mispred = br_mispred;
	assign ev.br_type    = br_type;

	// Each register takes one aligned word; the two low address bits must be zero.
	assign rgn      = reg_addr[7:5];
	assign idx      = reg_addr[4:2];
	assign aligned  = (reg_addr[1:0] == 2'h0);
	assign event_select_control_reg_hit = aligned && rgn == `PESD_RGN_EVENT_SELECT_CONTROL_REG && idx < 3'(`PESD_N_EVENT_SELECT_CONTROL_REG);
	assign counter_config_control_reg_hit = aligned && rgn == `PESD_RGN_COUNTER_CONFIG_CONTROL_REG;
	assign cnt_hit  = aligned && rgn == `PESD_RGN_CNT;

	// Only the code and mask fields are stored, so reserved bits always read zero.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `PESD_N_EVENT_SELECT_CONTROL_REG; i++) begin
				event_select_control_reg[i] <= `PESD_RST_VAL;
			end
		end else if (reg_wr && event_select_control_reg_hit) begin
			event_select_control_reg[idx] <= reg_wdata & `PESD_EVENT_SELECT_CONTROL_REG_WMASK;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `PESD_N_CNT; i++) begin
				counter_config_control_reg[i] <= `PESD_RST_VAL;
			end
		end else if (reg_wr && counter_config_control_reg_hit) begin
			counter_config_control_reg[idx] <= reg_wdata & `PESD_COUNTER_CONFIG_CONTROL_REG_WMASK;
		end
	end

	// Counters 0 to 3 serve the front-bus registers, 4 to 7 the sequencer and branch
	// registers; each pair shares the register of its bank.
	for (genvar k = 0; k < `PESD_N_CNT; k++) begin : g_cnt
		localparam int BANK = (k / 2) % 2;
		localparam bit PWR  = (k < `PESD_POWER_CNTS);
		logic wr_here;

		assign wr_here = reg_wr && cnt_hit && idx == 3'(k);

		pesd_counter_qual #(
			.POWER_SIDE (PWR)
		) u_qual (
			.event_select_control_reg_fsb (event_select_control_reg[32'(`PESD_EVENT_SELECT_CONTROL_REG_FSB) + BANK]),
			.event_select_control_reg_seq (event_select_control_reg[32'(`PESD_EVENT_SELECT_CONTROL_REG_SEQ) + BANK]),
			.event_select_control_reg_bru (event_select_control_reg[32'(`PESD_EVENT_SELECT_CONTROL_REG_BRU) + BANK]),
			.counter_config_control_reg     (counter_config_control_reg[k]),
			.ev       (ev),
			.inc      (inc[k])
		);

		// A software load wins over an increment in the same cycle.
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				cnt[k] <= CNT_W'(`PESD_RST_VAL);
			end else if (wr_here) begin
				cnt[k] <= reg_wdata[CNT_W-1:0];
			end else begin
				cnt[k] <= cnt[k] + CNT_W'(inc[k]);
			end
		end
	end

	// Unmapped or misaligned reads return zero.
	always_comb begin
		next_rdata = 32'h00000000;
		if (reg_rd) begin
			if (event_select_control_reg_hit) begin
				next_rdata = event_select_control_reg[idx];
			end else if (counter_config_control_reg_hit) begin
				next_rdata = counter_config_control_reg[idx];
			end else if (cnt_hit) begin
				next_rdata = 32'(cnt[idx]);
			end
		end
	end

	// Read data stand only in the cycle after the strobe and are zero otherwise.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 32'h00000000;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	// Helper decode for the checks below; nothing in the datapath reads it.
	// Each check watches the counter whose bank carries the event that it guards.
	logic             c0_power;
	logic             c2_nomask;
	logic             c3_wrong_sel;
	logic             c4_seq;
	logic             c4_xfer;
	logic             c4_xfer_off;
	logic             c5_bru;
	logic             c5_mispred;
	logic             c6_uq;
	logic             c7_branch;
	logic [1:0]       uq_pop;
	logic [3:0]       br_sel5;
	logic [3:0]       br_sel7;
	logic [CNT_W-1:0] cnt_sel;

	assign c0_power = counter_config_control_reg[0][`PESD_EN_BIT]
		&& counter_config_control_reg[0][`PESD_SEL_MSB:`PESD_SEL_LSB] == `PESD_SEL_POWER
		&& event_select_control_reg[0][`PESD_CODE_MSB:`PESD_CODE_LSB] == `PESD_CODE_POWER
		&& event_select_control_reg[0][`PESD_MASK_LSB + `PESD_MB_RUNNING];
	assign c2_nomask = counter_config_control_reg[2][`PESD_EN_BIT]
		&& counter_config_control_reg[2][`PESD_SEL_MSB:`PESD_SEL_LSB] == `PESD_SEL_POWER
		&& event_select_control_reg[1][`PESD_CODE_MSB:`PESD_CODE_LSB] == `PESD_CODE_POWER
		&& !event_select_control_reg[1][`PESD_MASK_LSB + `PESD_MB_RUNNING];
	assign c3_wrong_sel = counter_config_control_reg[3][`PESD_EN_BIT]
		&& counter_config_control_reg[3][`PESD_SEL_MSB:`PESD_SEL_LSB] != `PESD_SEL_POWER;
	assign c4_seq = counter_config_control_reg[4][`PESD_EN_BIT]
		&& counter_config_control_reg[4][`PESD_SEL_MSB:`PESD_SEL_LSB] == `PESD_SEL_SEQ;
	assign c5_bru = counter_config_control_reg[5][`PESD_EN_BIT]
		&& counter_config_control_reg[5][`PESD_SEL_MSB:`PESD_SEL_LSB] == `PESD_SEL_BRANCH;
	assign c4_xfer = c4_seq
		&& event_select_control_reg[2][`PESD_CODE_MSB:`PESD_CODE_LSB] == `PESD_CODE_XFER
		&& event_select_control_reg[2][`PESD_MASK_LSB + `PESD_MB_ROM_SWITCH];
	assign c4_xfer_off = c4_seq
		&& event_select_control_reg[2][`PESD_CODE_MSB:`PESD_CODE_LSB] == `PESD_CODE_XFER
		&& !event_select_control_reg[2][`PESD_MASK_LSB + `PESD_MB_ROM_SWITCH];
	assign c5_mispred = c5_bru
		&& event_select_control_reg[4][`PESD_CODE_MSB:`PESD_CODE_LSB] == `PESD_CODE_MISPRED;
	assign c6_uq = counter_config_control_reg[6][`PESD_EN_BIT]
		&& counter_config_control_reg[6][`PESD_SEL_MSB:`PESD_SEL_LSB] == `PESD_SEL_SEQ
		&& event_select_control_reg[3][`PESD_CODE_MSB:`PESD_CODE_LSB] == `PESD_CODE_UQ;
	assign c7_branch = counter_config_control_reg[7][`PESD_EN_BIT]
		&& counter_config_control_reg[7][`PESD_SEL_MSB:`PESD_SEL_LSB] == `PESD_SEL_BRANCH
		&& event_select_control_reg[5][`PESD_CODE_MSB:`PESD_CODE_LSB] == `PESD_CODE_BRANCH;
	assign br_sel5 = event_select_control_reg[4][`PESD_MASK_LSB + `PESD_MB_BR_MSB:`PESD_MASK_LSB + `PESD_MB_BR_LSB]
		& br_type;
	assign br_sel7 = event_select_control_reg[5][`PESD_MASK_LSB + `PESD_MB_BR_MSB:`PESD_MASK_LSB + `PESD_MB_BR_LSB]
		& br_type;
	assign uq_pop = {1'b0, event_select_control_reg[3][`PESD_MASK_LSB] & src_trace_build}
		+ {1'b0, event_select_control_reg[3][`PESD_MASK_LSB + 1] & src_trace_deliver}
		+ {1'b0, event_select_control_reg[3][`PESD_MASK_LSB + 2] & src_rom};
	assign cnt_sel = cnt[idx];

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_no_cnt_wr(int n);
		!(reg_wr && cnt_hit && idx == 3'(n));
	endsequence

	sequence s_escr0_write;
		reg_wr && reg_addr == 8'h00;
	endsequence

	sequence s_escr0_read;
		reg_rd && !reg_wr && reg_addr == 8'h00;
	endsequence

	power_counts_a: assert property (
		(c0_power && proc_running) and s_no_cnt_wr(0)
		|=> cnt[0] == $past(cnt[0]) + CNT_W'(1))
		else $error("power counter missed an active cycle");

	power_idle_a: assert property (
		(c0_power && !proc_running) and s_no_cnt_wr(0)
		|=> cnt[0] == $past(cnt[0]))
		else $error("power counter moved while stopped");

	power_mask_a: assert property (
		c2_nomask and s_no_cnt_wr(2)
		|=> $stable(cnt[2]))
		else $error("power counter moved with its mask bit clear");

	power_side_a: assert property (
		c3_wrong_sel and s_no_cnt_wr(3)
		|=> $stable(cnt[3]))
		else $error("power counter moved under another select");

	rom_switch_a: assert property (
		(c4_xfer && trace_to_rom_switch_event) and s_no_cnt_wr(4)
		|=> cnt[4] == $past(cnt[4]) + CNT_W'(1))
		else $error("rom switch not counted");

	rom_switch_quiet_a: assert property (
		(c4_xfer && !trace_to_rom_switch_event) and s_no_cnt_wr(4)
		|=> $stable(cnt[4]))
		else $error("rom switch counter moved with no switch");

	rom_mask_a: assert property (
		(c4_xfer_off && trace_to_rom_switch_event) and s_no_cnt_wr(4)
		|=> $stable(cnt[4]))
		else $error("rom switch counted with its mask bit clear");

	queue_writes_a: assert property (
		c6_uq and s_no_cnt_wr(6)
		|=> cnt[6] == $past(cnt[6]) + CNT_W'($past(uq_pop)))
		else $error("queue write count wrong");

	queue_src_a: assert property (
		(c6_uq && src_trace_build && src_trace_deliver && src_rom
		&& event_select_control_reg[3][`PESD_MASK_LSB + 2:`PESD_MASK_LSB] == 3'h7) and s_no_cnt_wr(6)
		|=> cnt[6] == $past(cnt[6]) + CNT_W'(3))
		else $error("three queue sources not counted as three");

	queue_none_a: assert property (
		(c6_uq && !src_trace_build && !src_trace_deliver && !src_rom) and s_no_cnt_wr(6)
		|=> $stable(cnt[6]))
		else $error("queue counter moved with no write");

	queue_step_a: assert property (
		s_no_cnt_wr(6)
		|=> cnt[6] - $past(cnt[6]) <= CNT_W'(3))
		else $error("queue counter jumped by more than three");

	mispred_counts_a: assert property (
		(c5_mispred && br_retire && br_mispred && (|br_sel5)) and s_no_cnt_wr(5)
		|=> cnt[5] == $past(cnt[5]) + CNT_W'(1))
		else $error("mispredicted branch not counted");

	mispred_step_a: assert property (
		s_no_cnt_wr(5)
		|=> cnt[5] - $past(cnt[5]) <= CNT_W'(1))
		else $error("mispredict counter jumped by more than one");

	mispred_type_a: assert property (
		(c5_mispred && br_retire && br_mispred && !(|br_sel5)) and s_no_cnt_wr(5)
		|=> $stable(cnt[5]))
		else $error("unselected branch type counted");

	mispred_only_a: assert property (
		(c5_mispred && br_retire && !br_mispred) and s_no_cnt_wr(5)
		|=> $stable(cnt[5]))
		else $error("correct branch counted as mispredicted");

	branch_counts_a: assert property (
		(c7_branch && br_retire) and s_no_cnt_wr(7)
		|=> cnt[7] == $past(cnt[7]) + CNT_W'($past(|br_sel7)))
		else $error("retired branch count wrong");

	branch_idle_a: assert property (
		(c7_branch && !br_retire) and s_no_cnt_wr(7)
		|=> $stable(cnt[7]))
		else $error("branch counter moved with no retirement");

	disabled_hold_a: assert property (
		(!counter_config_control_reg[1][`PESD_EN_BIT] && !reg_wr) [*3]
		|=> $stable(cnt[1]))
		else $error("disabled counter moved");

	field_store_a: assert property (
		s_escr0_write ##1 s_escr0_read
		|=> reg_rdata == ($past(reg_wdata, 2) & `PESD_EVENT_SELECT_CONTROL_REG_WMASK))
		else $error("event register fields not kept");

	event_select_control_reg_mask_a: assert property (
		reg_wr && event_select_control_reg_hit
		|=> event_select_control_reg[$past(idx)] == ($past(reg_wdata) & `PESD_EVENT_SELECT_CONTROL_REG_WMASK))
		else $error("event register write not masked");

	counter_config_control_reg_mask_a: assert property (
		reg_wr && counter_config_control_reg_hit
		|=> counter_config_control_reg[$past(idx)] == ($past(reg_wdata) & `PESD_COUNTER_CONFIG_CONTROL_REG_WMASK))
		else $error("config register write not masked");

	event_select_control_reg_hold_a: assert property (
		!reg_wr
		|=> $stable(event_select_control_reg[0]) && $stable(counter_config_control_reg[0]))
		else $error("select register moved with no write");

	cnt_load_a: assert property (
		reg_wr && cnt_hit
		|=> cnt[$past(idx)] == $past(reg_wdata[CNT_W-1:0]))
		else $error("counter load lost");

	cnt_read_a: assert property (
		reg_rd && cnt_hit
		|=> reg_rdata == 32'($past(cnt_sel)))
		else $error("counter read wrong");

	read_zero_a: assert property (
		!reg_rd |=> reg_rdata == 32'h00000000)
		else $error("read data outside the answer cycle");

	unmapped_read_a: assert property (
		reg_rd && !event_select_control_reg_hit && !counter_config_control_reg_hit && !cnt_hit
		|=> reg_rdata == 32'h00000000)
		else $error("unmapped read not zero");
endmodule

// ---- pesd_params.svh ----
// Register layout, event codes and address map of the event-select decoder.
`ifndef PESD_PARAMS_SVH
`define PESD_PARAMS_SVH
`define PESD_CODE_MSB       30
`define PESD_CODE_LSB       25
`define PESD_MASK_MSB       24
`define PESD_MASK_LSB       9
`define PESD_SEL_MSB        15
`define PESD_SEL_LSB        13
`define PESD_EN_BIT         12
`define PESD_CODE_POWER     6'h13
`define PESD_CODE_XFER      6'h05
`define PESD_CODE_UQ        6'h09
`define PESD_CODE_MISPRED   6'h05
`define PESD_CODE_BRANCH    6'h04
`define PESD_SEL_POWER      3'h6
`define PESD_SEL_SEQ        3'h0
`define PESD_SEL_BRANCH     3'h2
`define PESD_MB_RUNNING     0
`define PESD_MB_ROM_SWITCH  0
`define PESD_MB_UQ_MSB      2
`define PESD_MB_UQ_LSB      0
`define PESD_MB_BR_MSB      4
`define PESD_MB_BR_LSB      1
`define PESD_EVENT_SELECT_CONTROL_REG_WMASK     32'h7FFFFE00
`define PESD_COUNTER_CONFIG_CONTROL_REG_WMASK     32'h0000F000
`define PESD_RST_VAL        32'h00000000
`define PESD_RGN_EVENT_SELECT_CONTROL_REG       3'h0
`define PESD_RGN_COUNTER_CONFIG_CONTROL_REG       3'h1
`define PESD_RGN_CNT        3'h2
`define PESD_N_EVENT_SELECT_CONTROL_REG         6
`define PESD_N_CNT          8
`define PESD_EVENT_SELECT_CONTROL_REG_FSB       3'h0
`define PESD_EVENT_SELECT_CONTROL_REG_SEQ       3'h2
`define PESD_EVENT_SELECT_CONTROL_REG_BRU       3'h4
`define PESD_POWER_CNTS     4
`endif

// ---- pesd_pkg.sv ----
// Types shared by the event-select decoder modules.
package pesd_pkg;
	typedef logic [5:0]  pesd_code_t;
	typedef logic [2:0]  pesd_sel_t;
	typedef logic [15:0] pesd_mask_t;
	typedef enum logic [2:0] {
		PESD_K_NONE    = 3'b000,
		PESD_K_POWER   = 3'b001,
		PESD_K_XFER    = 3'b010,
		PESD_K_UQ      = 3'b011,
		PESD_K_MISPRED = 3'b100,
		PESD_K_BRANCH  = 3'b101
	} pesd_kind_t;
endpackage

// ---- pesd_event_if.sv ----
// Pipeline occurrence signals handed from the top to each counter qualifier.
`timescale 1ns/1ps
interface pesd_event_if;
	logic       running;
	logic       rom_switch;
	logic [2:0] uq_src;
	logic       br_retire;
	logic       br_mispred;
	logic [3:0] br_type;
	modport drive (output running, rom_switch, uq_src, br_retire, br_mispred, br_type);
	modport sample (input running, rom_switch, uq_src, br_retire, br_mispred, br_type);
endinterface

// ---- pesd_counter_qual.sv ----
// Decides the per-cycle increment of one counter from its select registers.
`timescale 1ns/1ps
`include "pesd_params.svh"
module pesd_counter_qual #(
	parameter bit POWER_SIDE = 1'b0
) (
	input  wire logic [31:0] event_select_control_reg_fsb,
	input  wire logic [31:0] event_select_control_reg_seq,
	input  wire logic [31:0] event_select_control_reg_bru,
	input  wire logic [31:0] counter_config_control_reg,
	pesd_event_if.sample     ev,
	output logic [1:0]       inc
);
	pesd_pkg::pesd_sel_t  sel;
	pesd_pkg::pesd_kind_t kind;
	pesd_pkg::pesd_mask_t mask;
	logic [2:0]           uq_hit;
	logic [3:0]           br_hit;

	assign sel = counter_config_control_reg[`PESD_SEL_MSB:`PESD_SEL_LSB];

	// The select code picks which event register feeds this counter.
	always_comb begin
		kind = pesd_pkg::PESD_K_NONE;
		mask = '0;
		if (counter_config_control_reg[`PESD_EN_BIT]) begin
			if (POWER_SIDE && sel == `PESD_SEL_POWER) begin
				mask = event_select_control_reg_fsb[`PESD_MASK_MSB:`PESD_MASK_LSB];
				if (event_select_control_reg_fsb[`PESD_CODE_MSB:`PESD_CODE_LSB] == `PESD_CODE_POWER)
					kind = pesd_pkg::PESD_K_POWER;
			end else if (!POWER_SIDE && sel == `PESD_SEL_SEQ) begin
				mask = event_select_control_reg_seq[`PESD_MASK_MSB:`PESD_MASK_LSB];
				if (event_select_control_reg_seq[`PESD_CODE_MSB:`PESD_CODE_LSB] == `PESD_CODE_XFER)
					kind = pesd_pkg::PESD_K_XFER;
				else if (event_select_control_reg_seq[`PESD_CODE_MSB:`PESD_CODE_LSB] == `PESD_CODE_UQ)
					kind = pesd_pkg::PESD_K_UQ;
			end else if (!POWER_SIDE && sel == `PESD_SEL_BRANCH) begin
				mask = event_select_control_reg_bru[`PESD_MASK_MSB:`PESD_MASK_LSB];
				if (event_select_control_reg_bru[`PESD_CODE_MSB:`PESD_CODE_LSB] == `PESD_CODE_MISPRED)
					kind = pesd_pkg::PESD_K_MISPRED;
				else if (event_select_control_reg_bru[`PESD_CODE_MSB:`PESD_CODE_LSB] == `PESD_CODE_BRANCH)
					kind = pesd_pkg::PESD_K_BRANCH;
			end
		end
	end

	assign uq_hit = mask[`PESD_MB_UQ_MSB:`PESD_MB_UQ_LSB] & ev.uq_src;
	assign br_hit = mask[`PESD_MB_BR_MSB:`PESD_MB_BR_LSB] & ev.br_type;

	// Queue writes from several sources in one cycle each count once.
	always_comb begin
		case (kind)
			pesd_pkg::PESD_K_POWER:
				inc = {1'b0, mask[`PESD_MB_RUNNING] & ev.running};
			pesd_pkg::PESD_K_XFER:
				inc = {1'b0, mask[`PESD_MB_ROM_SWITCH] & ev.rom_switch};
			pesd_pkg::PESD_K_UQ:
				inc = {1'b0, uq_hit[0]} + {1'b0, uq_hit[1]} + {1'b0, uq_hit[2]};
			pesd_pkg::PESD_K_MISPRED:
				inc = {1'b0, ev.br_retire & ev.br_mispred & (|br_hit)};
			pesd_pkg::PESD_K_BRANCH:
				inc = {1'b0, ev.br_retire & (|br_hit)};
			default:
				inc = 2'h0;
		endcase
	end
endmodule

// ---- pesd_pipe_model.sv ----
// Behavioural pipeline that raises event occurrences from a random word.
`timescale 1ns/1ps
module pesd_pipe_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        en,
	input  wire logic [31:0] rnd,
	output logic             proc_running,
	output logic             rom_switch,
	output logic             src_trace_build,
	output logic             src_trace_deliver,
	output logic             src_rom,
	output logic             br_retire,
	output logic             br_mispred,
	output logic      [3:0]  br_type
);
	// While idle no occurrence is reported, so the counters stay still for reads.
	always_ff @(posedge clk or posedge rst) begin
		if (rst || !en) begin
			{proc_running, rom_switch, src_trace_build, src_trace_deliver} <= 4'h0;
			{src_rom, br_retire, br_mispred, br_type} <= 7'h00;
		end else begin
			proc_running      <= rnd[0];
			rom_switch        <= rnd[1] & rnd[2];
			src_trace_build   <= rnd[3];
			src_trace_deliver <= rnd[4];
			src_rom           <= rnd[5];
			br_retire         <= rnd[6];
			br_mispred        <= rnd[6] & rnd[7];
			br_type           <= rnd[11:8];
		end
	end
endmodule

// ---- perf_event_select_decode_tb.sv ----
// Self-checking bench: programs the select registers, runs random events, reads counters.
`timescale 1ns/1ps
module perf_event_select_decode_tb;
	logic        clk, rst, en, rd_d;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rnd, x;
	logic        reg_wr, reg_rd, run, sw, bld, dlv, rom, ret, mis;
	logic [3:0]  typ, mm, mb;
	logic [2:0]  mu;
	logic        mrun, msw;
	logic [31:0] q[$];
	int          fails, n_compared, t[8], b[8];
	logic [15:0] cc[8] = '{16'hD000, 16'hC000, 16'hD000, 16'h5000,
		16'h1000, 16'h5000, 16'h1000, 16'h5000};

	pesd_top dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .proc_running(run),
		.trace_to_rom_switch_event(sw), .src_trace_build(bld), .src_trace_deliver(dlv),
		.src_rom(rom), .br_retire(ret), .br_mispred(mis), .br_type(typ));
	pesd_pipe_model pipe (.clk(clk), .rst(rst), .en(en), .rnd(rnd), .proc_running(run),
		.rom_switch(sw), .src_trace_build(bld), .src_trace_deliver(dlv), .src_rom(rom),
		.br_retire(ret), .br_mispred(mis), .br_type(typ));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction

	function automatic logic [31:0] ev(input logic [5:0] code, input logic [15:0] m);
		return {1'b0, code, m, 9'h000};
	endfunction

	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("ERROR t=%0t read data %h expected %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		q.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask

	// A read strobe right behind a write to the same word must see the new value.
	task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		q.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Reference tallies, sampled at the same edge at which the counters act.
	always @(posedge clk) begin
		t[0] += run & mrun;
		t[4] += sw & msw;
		t[5] += ret & mis & (|(mm & typ));
		t[6] += $countones(mu & {rom, dlv, bld});
		t[7] += ret & (|(mb & typ));
		rnd <= x;
		x = xs(x);
	end

	// Read data stand in the cycle after the strobe only, and read 0 otherwise.
	always @(posedge clk) begin
		if (rd_d && q.size() > 0)
			chk(q.pop_front(), reg_rdata);
		else
			chk(32'h00000000, reg_rdata);
		rd_d <= reg_rd;
	end

	initial begin
		rst = 1'b0; en = 1'b0; rd_d = 1'b0; x = 32'h000132BE; rnd = 32'h00000000;
		reg_addr = 8'h00; reg_wdata = 32'h00000000; reg_wr = 1'b0; reg_rd = 1'b0;
		{mu, mm, mb, mrun, msw} = 13'h0000;
		// Raising reset after time zero lets every reset process see its edge.
		#1 rst = 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(8'h40, 32'h00000000);
		wr(8'h04, 32'hFFFFFFFF);
		rd(8'h04, 32'h7FFFFE00);
		wr(8'h18, 32'hFFFFFFFF);
		rd(8'h18, 32'h00000000);
		rd(8'h60, 32'h00000000);
		wr_rd(8'h00, 32'hFFFFFFFF, 32'h7FFFFE00);
		$display("register map test done");
		for (int p = 1; p < 8; p++) begin
			mu = p[2:0]; mm = {p[0], p[2:0]}; mb = 4'hF ^ mm; mrun = p[2]; msw = p[1];
			wr(8'h00, ev(6'h13, {15'h0000, mrun}));
			wr(8'h04, ev(6'h13, 16'h0000));
			wr(8'h08, ev(6'h05, {15'h0000, msw}));
			wr(8'h0C, ev(6'h09, {13'h0000, mu}));
			wr(8'h10, ev(6'h05, {11'h000, mm, 1'b0}));
			wr(8'h14, ev(6'h04, {11'h000, mb, 1'b0}));
			for (int n = 0; n < 8; n++) begin
				wr(8'h20 + 8'(4 * n), {16'h0000, cc[n]});
				wr(8'h40 + 8'(4 * n), 32'h00000000);
			end
			b = t;
			en <= 1'b1;
			repeat (64) @(posedge clk);
			en <= 1'b0;
			repeat (3) @(posedge clk);
			rd(8'h00, ev(6'h13, {15'h0000, mrun}));
			for (int n = 0; n < 8; n++)
				rd(8'h40 + 8'(4 * n), 32'(t[n] - b[n]));
			$display("event phase %0d done", p);
		end
		repeat (3) @(posedge clk);
		results();
	end

	initial begin
		#200000;
		fails++;
		$display("ERROR t=%0t run did not finish", $time);
		results();
	end
endmodule
